// File: design/io_space_pkg.sv
// Constants for the low I/O register space decoder
package io_space_pkg;
    // Space sizes and data-space mirror
    localparam int         IO_LOCATIONS   = 64;
    localparam logic [5:0] BIT_OP_LAST    = 6'h1F;
    localparam logic [7:0] DATA_IO_BASE   = 8'h20;
    localparam logic [7:0] DATA_IO_LAST   = 8'h5F;
    localparam logic [7:0] EXT_IO_BASE    = 8'h60;
    localparam int         PORT_COUNT     = 4;
    localparam int         PORT_STRIDE    = 3;
    localparam logic [7:0] RESET_VALUE    = 8'h00;
    // Register offsets in I/O space
    localparam logic [5:0] PIN_LEVEL_A    = 6'h00;
    localparam logic [5:0] DIRECTION_A    = 6'h01;
    localparam logic [5:0] OUTPUT_LATCH_A = 6'h02;
    localparam logic [5:0] PIN_LEVEL_B    = 6'h03;
    localparam logic [5:0] PIN_LEVEL_C    = 6'h06;
    localparam logic [5:0] PIN_LEVEL_D    = 6'h09;
    localparam logic [5:0] TIMER0_FLAGS   = 6'h15;
    localparam logic [5:0] TIMER1_FLAGS   = 6'h16;
    localparam logic [5:0] TIMER2_FLAGS   = 6'h17;
    localparam logic [5:0] PIN_CHG_FLAGS  = 6'h1B;
    localparam logic [5:0] EXT_IRQ_FLAGS  = 6'h1C;
    localparam logic [5:0] EXT_IRQ_MASK   = 6'h1D;
    localparam logic [5:0] SCRATCH_REG_0  = 6'h1E;
    localparam logic [5:0] EEPROM_CONTROL = 6'h1F;
    localparam logic [5:0] EEPROM_DATA    = 6'h20;
    localparam logic [5:0] EEPROM_ADDR_LO = 6'h21;
    localparam logic [5:0] EEPROM_ADDR_HI = 6'h22;
    localparam logic [5:0] PRESCALER_CTRL = 6'h23;
    localparam logic [5:0] TIMER0_CTRL_A  = 6'h24;
    localparam logic [5:0] TIMER0_CTRL_B  = 6'h25;
    localparam logic [5:0] TIMER0_COUNT   = 6'h26;
    localparam logic [5:0] TIMER0_CMP_A   = 6'h27;
    localparam logic [5:0] TIMER0_CMP_B   = 6'h28;
    localparam logic [5:0] SCRATCH_REG_1  = 6'h2A;
    localparam logic [5:0] SCRATCH_REG_2  = 6'h2B;
    localparam logic [5:0] SPI_CONTROL    = 6'h2C;
    localparam logic [5:0] SPI_STATUS     = 6'h2D;
    localparam logic [5:0] SPI_DATA       = 6'h2E;
    localparam logic [5:0] COMPARATOR_CS  = 6'h30;
    localparam logic [5:0] DEBUG_CHANNEL  = 6'h31;
    // Writable bit masks
    localparam logic [7:0] MASK_FULL      = 8'hFF;
    localparam logic [7:0] MASK_NONE      = 8'h00;
    localparam logic [7:0] MASK_EXT_IRQ   = 8'h07;
    localparam logic [7:0] MASK_EE_CTRL   = 8'h3F;
    localparam logic [7:0] MASK_EE_ADR_HI = 8'h0F;
    localparam logic [7:0] MASK_PRESCALER = 8'h83;
    localparam logic [7:0] MASK_T0_CTRL_A = 8'hF3;
    localparam logic [7:0] MASK_T0_CTRL_B = 8'hCF;
    localparam logic [7:0] MASK_SPI_STAT  = 8'h01;
    localparam logic [7:0] MASK_CMP_RW    = 8'hCF;
    // Write-one-to-clear flag masks
    localparam logic [7:0] FLAGS_TIMER0   = 8'h07;
    localparam logic [7:0] FLAGS_TIMER1   = 8'h27;
    localparam logic [7:0] FLAGS_TIMER2   = 8'h07;
    localparam logic [7:0] FLAGS_PIN_CHG  = 8'h0F;
    localparam logic [7:0] FLAGS_EXT_IRQ  = 8'h07;
    localparam logic [7:0] FLAGS_CMP      = 8'h10;
    localparam int         CMP_LEVEL_BIT  = 5;
    localparam int         CMP_FLAG_BIT   = 4;
endpackage : io_space_pkg

// File: design/io_register_space_decoder.sv
// Low I/O register space decoder with bit operations and flag clearing
// Notes on behaviour
// - Bit set and clear reach 0x00-0x1F only
// - Skip tests examine one bit, low 32
// - Writing one clears flags; zero keeps
// - Bit operations rewrite the whole register byte
// - I/O instructions address 64 locations unshifted
// - Data space sees I/O at plus 0x20
// - Extended region reached only by data space
// - Ports are pin, direction, latch triplets
`timescale 1ns/1ps
module io_register_space_decoder
    import io_space_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Dedicated I/O instructions
    input  wire logic        io_read,
    input  wire logic        io_write,
    input  wire logic [5:0]  io_addr,
    // Data-space load and store
    input  wire logic        data_read,
    input  wire logic        data_write,
    input  wire logic [7:0]  data_addr,
    input  wire logic [7:0]  write_data,
    // Single-bit operations
    input  wire logic        bit_set_op,
    input  wire logic        bit_clear_op,
    input  wire logic        skip_if_bit_set,
    input  wire logic        skip_if_bit_clear,
    input  wire logic [4:0]  bit_addr,
    input  wire logic [2:0]  bit_select,
    // Answers to the core
    output logic [7:0]       read_data,
    output logic             read_valid,
    output logic             skip_result,
    output logic             skip_valid,
    // Extended region forwarded elsewhere
    output logic             ext_read,
    output logic             ext_write,
    // Port pins, four ports of eight
    input  wire logic [31:0] pin_level,
    output logic [31:0]      port_direction,
    output logic [31:0]      port_output,
    // Hardware flag events, same clock domain
    input  wire logic [7:0]  timer0_flag_set,
    input  wire logic [7:0]  timer1_flag_set,
    input  wire logic [7:0]  timer2_flag_set,
    input  wire logic [7:0]  pin_change_flag_set,
    input  wire logic [7:0]  ext_irq_flag_set,
    input  wire logic        comparator_flag_set,
    input  wire logic        comparator_level,
    // Write notice for peripherals
    output logic             periph_write,
    output logic [5:0]       periph_index,
    output logic [7:0]       periph_data
);

    // Register storage, one byte per location
    logic [7:0]  store [0:IO_LOCATIONS-1];
    // Two-stage pin synchroniser
    logic [31:0] pin_meta;
    logic [31:0] pin_sync;
    // Arbitrated access
    logic        data_io_hit;
    logic        io_cmd;
    logic        data_cmd;
    logic        bit_cmd;
    logic        skip_cmd;
    logic [5:0]  acc_idx;
    logic        acc_write;
    logic        acc_read;
    logic [7:0]  acc_rval;
    logic [7:0]  next_wval;

    // Pins are asynchronous, so two flops before any reader
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_level;
            pin_sync <= pin_meta;
        end
    end

    // Writable bits per location; anything unlisted other than port direction and latch is reserved
    function automatic logic [7:0] rw_mask(input logic [5:0] a);
        case (a)
            EXT_IRQ_MASK:   rw_mask = MASK_EXT_IRQ;
            EEPROM_CONTROL: rw_mask = MASK_EE_CTRL;
            EEPROM_ADDR_HI: rw_mask = MASK_EE_ADR_HI;
            PRESCALER_CTRL: rw_mask = MASK_PRESCALER;
            TIMER0_CTRL_A:  rw_mask = MASK_T0_CTRL_A;
            TIMER0_CTRL_B:  rw_mask = MASK_T0_CTRL_B;
            SPI_STATUS:     rw_mask = MASK_SPI_STAT;
            COMPARATOR_CS:  rw_mask = MASK_CMP_RW;
            SCRATCH_REG_0, EEPROM_DATA, EEPROM_ADDR_LO,
            TIMER0_COUNT, TIMER0_CMP_A, TIMER0_CMP_B,
            SCRATCH_REG_1, SCRATCH_REG_2, SPI_CONTROL,
            SPI_DATA, DEBUG_CHANNEL:
                            rw_mask = MASK_FULL;
            default: begin
                // Direction and latch of each port triplet
                if (a < 6'(PORT_COUNT * PORT_STRIDE) && a % 6'(PORT_STRIDE) != 6'd0)
                    rw_mask = MASK_FULL;
                else
                    rw_mask = MASK_NONE;
            end
        endcase
    endfunction : rw_mask

    // Flag bits that clear on a written one
    function automatic logic [7:0] flag_mask(input logic [5:0] a);
        case (a)
            TIMER0_FLAGS:  flag_mask = FLAGS_TIMER0;
            TIMER1_FLAGS:  flag_mask = FLAGS_TIMER1;
            TIMER2_FLAGS:  flag_mask = FLAGS_TIMER2;
            PIN_CHG_FLAGS: flag_mask = FLAGS_PIN_CHG;
            EXT_IRQ_FLAGS: flag_mask = FLAGS_EXT_IRQ;
            COMPARATOR_CS: flag_mask = FLAGS_CMP;
            default:       flag_mask = MASK_NONE;
        endcase
    endfunction : flag_mask

    // Hardware set requests per location
    function automatic logic [7:0] hw_set(input logic [5:0] a);
        case (a)
            TIMER0_FLAGS:  hw_set = timer0_flag_set;
            TIMER1_FLAGS:  hw_set = timer1_flag_set;
            TIMER2_FLAGS:  hw_set = timer2_flag_set;
            PIN_CHG_FLAGS: hw_set = pin_change_flag_set;
            EXT_IRQ_FLAGS: hw_set = ext_irq_flag_set;
            COMPARATOR_CS: hw_set = {3'h0, comparator_flag_set, 4'h0};
            default:       hw_set = MASK_NONE;
        endcase
    endfunction : hw_set

    // Read view of a location, pins and comparator level live
    function automatic logic [7:0] read_of(input logic [5:0] a);
        case (a)
            PIN_LEVEL_A:   read_of = pin_sync[7:0];
            PIN_LEVEL_B:   read_of = pin_sync[15:8];
            PIN_LEVEL_C:   read_of = pin_sync[23:16];
            PIN_LEVEL_D:   read_of = pin_sync[31:24];
            COMPARATOR_CS: read_of = store[a] | {2'h0, comparator_level, 5'h00};
            default:       read_of = store[a];
        endcase
    endfunction : read_of

    // Data addresses 0x20-0x5F mirror the I/O space
    assign data_io_hit = (data_addr >= DATA_IO_BASE) && (data_addr <= DATA_IO_LAST);
    // One access per cycle: I/O, then data, then bit operations
    assign io_cmd   = io_read || io_write;
    assign data_cmd = !io_cmd && (data_read || data_write) && data_io_hit;
    assign bit_cmd  = !io_cmd && !(data_read || data_write)
                      && (bit_set_op || bit_clear_op);
    assign skip_cmd = !io_cmd && !(data_read || data_write) && !bit_cmd
                      && (skip_if_bit_set || skip_if_bit_clear);

    // Location and direction of the winning access
    always_comb begin
        if (io_cmd)
            acc_idx = io_addr;
        else if (data_cmd)
            acc_idx = 6'(data_addr - DATA_IO_BASE);
        else
            acc_idx = {1'b0, bit_addr};
    end
    assign acc_write = (io_cmd && io_write) || (data_cmd && data_write) || bit_cmd;
    assign acc_read  = (io_cmd && !io_write) || (data_cmd && !data_write);
    // Process form, so a change of the stored byte re-runs the read view
    always_comb begin
        acc_rval = read_of(acc_idx);
    end

    // Byte to write; bit operations read, modify, write all eight bits
    always_comb begin
        if (bit_cmd && bit_set_op)
            next_wval = acc_rval | (8'h01 << bit_select);
        else if (bit_cmd)
            next_wval = acc_rval & ~(8'h01 << bit_select);
        else
            next_wval = write_data;
    end

    // Extended region bypasses this decoder; I/O opcodes cannot reach it
    assign ext_read  = !io_cmd && data_read && (data_addr >= EXT_IO_BASE);
    assign ext_write = !io_cmd && !data_read && data_write
                       && (data_addr >= EXT_IO_BASE);

    // Each location updates on its own; a hardware set beats a clearing write
    genvar g;
    generate
        for (g = 0; g < IO_LOCATIONS; g++) begin : loc
            logic       hit;
            logic [7:0] rwm;
            logic [7:0] flm;
            assign hit = acc_write && (acc_idx == 6'(g));
            assign rwm = rw_mask(6'(g));
            assign flm = flag_mask(6'(g));
            always_ff @(posedge clock or posedge reset) begin
                if (reset) begin
                    store[g] <= RESET_VALUE;
                end else if (hit) begin
                    // Ones clear flags, zeros keep them, set wins
                    store[g] <= (next_wval & rwm)
                                | (store[g] & flm & ~next_wval)
                                | (hw_set(6'(g)) & flm);
                end else begin
                    store[g] <= store[g] | (hw_set(6'(g)) & flm);
                end
            end
        end
    endgenerate

    // Expose direction and latch of each port triplet
    genvar p;
    generate
        for (p = 0; p < PORT_COUNT; p++) begin : port
            assign port_direction[8*p +: 8] = store[PORT_STRIDE*p + 1];
            assign port_output[8*p +: 8]    = store[PORT_STRIDE*p + 2];
        end
    endgenerate

    // Read answer one cycle after the request
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            read_data  <= 8'h00;
            read_valid <= 1'b0;
        end else begin
            read_valid <= acc_read;
            if (acc_read)
                read_data <= acc_rval;
        end
    end

    // Skip test result; true means skip the next instruction
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            skip_result <= 1'b0;
            skip_valid  <= 1'b0;
        end else begin
            skip_valid <= skip_cmd;
            if (skip_cmd)
                skip_result <= (acc_rval[bit_select] == skip_if_bit_set);
        end
    end

    // Write notice, so peripherals can react to register writes
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            periph_write <= 1'b0;
            periph_index <= 6'h00;
            periph_data  <= 8'h00;
        end else begin
            periph_write <= acc_write;
            if (acc_write) begin
                periph_index <= acc_idx;
                periph_data  <= next_wval;
            end
        end
    end

    // Writing a latch by bit set leaves that bit high
    set_bit_a: assert property (@(posedge clock) disable iff (reset)
        (bit_cmd && bit_set_op && bit_addr == 5'(OUTPUT_LATCH_A))
        |=> port_output[$past(bit_select)] == 1'b1)
        else $error("bit set did not land");

    // Skip-if-set tracks the addressed direction bit
    skip_test_a: assert property (@(posedge clock) disable iff (reset)
        (skip_cmd && skip_if_bit_set && bit_addr == 5'(DIRECTION_A))
        |=> skip_valid && skip_result == $past(port_direction[bit_select]))
        else $error("skip result wrong");

    // A written one clears a flag without a new event
    w1c_clear_a: assert property (@(posedge clock) disable iff (reset)
        (io_write && io_addr == TIMER0_FLAGS && write_data == 8'hFF
         && timer0_flag_set == 8'h00) |=> store[TIMER0_FLAGS] == 8'h00)
        else $error("flag not cleared by one");

    // A written zero keeps flags
    w1c_keep_a: assert property (@(posedge clock) disable iff (reset)
        (io_write && io_addr == EXT_IRQ_FLAGS && write_data == 8'h00)
        |=> store[EXT_IRQ_FLAGS] == $past(store[EXT_IRQ_FLAGS]))
        else $error("flag lost on zero write");

    // Bit clear on a flag register clears every set flag except the selected bit, which is written back as zero and kept
    rmw_clear_a: assert property (@(posedge clock) disable iff (reset)
        (bit_cmd && bit_clear_op && bit_addr == 5'(TIMER1_FLAGS)
         && timer1_flag_set == 8'h00) |=> store[TIMER1_FLAGS] == 8'h00)
        else $error("read-modify-write kept a flag");

    // Dedicated read answers next cycle with the latch byte
    io_read_a: assert property (@(posedge clock) disable iff (reset)
        (io_read && !io_write && io_addr == OUTPUT_LATCH_A)
        |=> read_valid && read_data == $past(port_output[7:0]))
        else $error("I/O read answer wrong");

    // Data address 0x22 mirrors the port A latch
    data_mirror_a: assert property (@(posedge clock) disable iff (reset)
        (!io_cmd && data_read && data_addr == 8'h22)
        |=> read_valid && read_data == $past(port_output[7:0]))
        else $error("data mirror offset wrong");

    // Extended stores never touch local registers
    ext_only_a: assert property (@(posedge clock) disable iff (reset)
        (!io_cmd && !data_read && data_write && data_addr >= EXT_IO_BASE)
        |-> ext_write ##1 !periph_write)
        else $error("extended store decoded locally");

    // Port B latch sits at offset 0x05
    port_triplet_a: assert property (@(posedge clock) disable iff (reset)
        (io_write && io_addr == 6'h05) |=> port_output[15:8] == $past(write_data))
        else $error("port triplet layout wrong");

    // Reserved location reads zero even after a write
    reserved_zero_a: assert property (@(posedge clock) disable iff (reset)
        (io_read && !io_write && io_addr == 6'h0C)
        |=> read_valid && read_data == 8'h00)
        else $error("reserved location not zero");

endmodule : io_register_space_decoder

// File: testbench/core_model.sv
// Processor core model issuing I/O, data-space and single-bit requests
`timescale 1ns/1ps
module core_model (
    // Clock
    input  wire logic       clock,
    // Requests to the decoder
    output logic            io_read,
    output logic            io_write,
    output logic [5:0]      io_addr,
    output logic            data_read,
    output logic            data_write,
    output logic [7:0]      data_addr,
    output logic [7:0]      write_data,
    output logic            bit_set_op,
    output logic            bit_clear_op,
    output logic            skip_if_bit_set,
    output logic            skip_if_bit_clear,
    output logic [4:0]      bit_addr,
    output logic [2:0]      bit_select,
    // Answers from the decoder
    input  wire logic [7:0] read_data,
    input  wire logic       read_valid,
    input  wire logic       skip_result,
    input  wire logic       skip_valid,
    input  wire logic       ext_read,
    input  wire logic       ext_write
);
    logic ext_seen;  // Forward strobe seen while the last request stood

    // Drop strobes; address and data flip so a stale value never looks held
    task automatic release_bus();
        {io_read, io_write, data_read, data_write} = 4'h0;
        {bit_set_op, bit_clear_op, skip_if_bit_set, skip_if_bit_clear} = 4'h0;
        {io_addr, data_addr, write_data, bit_addr, bit_select} =
            ~{io_addr, data_addr, write_data, bit_addr, bit_select};
    endtask : release_bus

    // Idle bus at time zero
    initial begin
        {io_addr, data_addr, write_data, bit_addr, bit_select} = '0;
        ext_seen = 1'b0;
        release_bus();
    end

    // Byte access: 0 I/O read, 1 I/O write, 2 data load, 3 data store
    // Callers only write mapped addresses
    // Callers keep reserved bits zero, bar the reserved-bit probe and the 0xFF writes to the pin-level locations
    task automatic access(input int kind, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic valid);
        @(negedge clock);
        io_read    = (kind == 0);
        io_write   = (kind == 1);
        data_read  = (kind == 2);
        data_write = (kind == 3);
        io_addr    = addr[5:0];
        data_addr  = addr;
        write_data = wdata;
        #1 ext_seen = ext_read | ext_write;
        @(negedge clock);
        rdata = read_data;
        valid = read_valid;
        release_bus();
    endtask : access

    // Bit request: 0 set, 1 clear, 2 skip if set, 3 skip if clear
    task automatic bit_op(input int kind, input logic [4:0] addr, input logic [2:0] sel,
                          output logic res, output logic valid);
        @(negedge clock);
        bit_set_op        = (kind == 0);
        bit_clear_op      = (kind == 1);
        skip_if_bit_set   = (kind == 2);
        skip_if_bit_clear = (kind == 3);
        bit_addr          = addr;
        bit_select        = sel;
        @(negedge clock);
        res   = skip_result;
        valid = skip_valid;
        release_bus();
    endtask : bit_op
endmodule : core_model

// File: testbench/io_register_space_decoder_tb_top.sv
// Self-checking bench for the low I/O register space decoder
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module io_register_space_decoder_tb_top import io_space_pkg::*; ;
    logic        clock = 1'b0;  // 200 MHz system clock
    logic        reset;         // Active high
    logic [31:0] pin_level;     // Pins driven by the bench
    logic [7:0]  t0_set, t1_set, t2_set, pc_set, ei_set;  // Flag set pulses
    logic        cmp_set, cmp_level;                    // Comparator inputs
    logic        io_read, io_write, data_read, data_write, bit_set_op, bit_clear_op;
    logic        skip_if_bit_set, skip_if_bit_clear, read_valid, skip_result, skip_valid;
    logic        ext_read, ext_write, periph_write;
    logic [5:0]  io_addr, periph_index;
    logic [7:0]  data_addr, write_data, read_data, periph_data, rd, ex;
    logic [4:0]  bit_addr;
    logic [2:0]  bit_select;
    logic [31:0] port_direction, port_output;
    logic        vl, res;
    int          error_cnt = 0;
    int          checks_done = 0;

    // Half period of 2.5 ns
    always #2.5 clock = ~clock;

    io_register_space_decoder uut (.clock(clock), .reset(reset), .io_read(io_read),
        .io_write(io_write), .io_addr(io_addr), .data_read(data_read),
        .data_write(data_write), .data_addr(data_addr), .write_data(write_data),
        .bit_set_op(bit_set_op), .bit_clear_op(bit_clear_op),
        .skip_if_bit_set(skip_if_bit_set), .skip_if_bit_clear(skip_if_bit_clear),
        .bit_addr(bit_addr), .bit_select(bit_select), .read_data(read_data),
        .read_valid(read_valid), .skip_result(skip_result), .skip_valid(skip_valid),
        .ext_read(ext_read), .ext_write(ext_write), .pin_level(pin_level),
        .port_direction(port_direction), .port_output(port_output),
        .timer0_flag_set(t0_set), .timer1_flag_set(t1_set), .timer2_flag_set(t2_set),
        .pin_change_flag_set(pc_set), .ext_irq_flag_set(ei_set),
        .comparator_flag_set(cmp_set), .comparator_level(cmp_level),
        .periph_write(periph_write), .periph_index(periph_index), .periph_data(periph_data));

    core_model core (.clock(clock), .io_read(io_read), .io_write(io_write), .io_addr(io_addr),
        .data_read(data_read), .data_write(data_write), .data_addr(data_addr),
        .write_data(write_data), .bit_set_op(bit_set_op), .bit_clear_op(bit_clear_op),
        .skip_if_bit_set(skip_if_bit_set), .skip_if_bit_clear(skip_if_bit_clear),
        .bit_addr(bit_addr), .bit_select(bit_select), .read_data(read_data),
        .read_valid(read_valid), .skip_result(skip_result), .skip_valid(skip_valid),
        .ext_read(ext_read), .ext_write(ext_write));

    // Verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // I/O read with its answer judged
    task automatic rd_io(input logic [5:0] a, input logic [7:0] exp);
        core.access(0, {2'b00, a}, 8'h00, rd, vl);
        `CHK("read valid", 1'b1, vl)
        `CHK("read data", exp, rd)
    endtask : rd_io

    // I/O write
    task automatic wr_io(input logic [5:0] a, input logic [7:0] d);
        core.access(1, {2'b00, a}, d, rd, vl);
    endtask : wr_io

    // Every one of the 64 locations answers, all zero out of reset
    task automatic t_reset_map();
        for (int a = 0; a < IO_LOCATIONS; a++) begin
            rd_io(6'(a), RESET_VALUE);
        end
        `CHK("port outputs", 64'h0, {port_direction, port_output})
    endtask : t_reset_map

    // Pin, direction, latch triplets for all four ports
    task automatic t_ports();
        for (int p = 0; p < PORT_COUNT; p++) begin
            wr_io(6'(3 * p + 1), 8'hA0 ^ 8'(p));
            wr_io(6'(3 * p + 2), 8'h5A ^ 8'(p));
            `CHK("notice strobe", 1'b1, periph_write)
            `CHK("notice index", 6'(3 * p + 2), periph_index)
            `CHK("notice data", 8'h5A ^ 8'(p), periph_data)
            `CHK("direction", 8'hA0 ^ 8'(p), port_direction[8 * p +: 8])
            `CHK("latch", 8'h5A ^ 8'(p), port_output[8 * p +: 8])
            pin_level[8 * p +: 8] = 8'hC3 ^ 8'(p);
            repeat (3) @(negedge clock);
            wr_io(6'(3 * p), 8'hFF);
            rd_io(6'(3 * p), 8'hC3 ^ 8'(p));
            rd_io(6'(3 * p + 1), 8'hA0 ^ 8'(p));
        end
    endtask : t_ports

    // Data-space mirror at plus 0x20, nothing decoded below it
    task automatic t_mirror();
        core.access(3, 8'h3E, 8'h69, rd, vl);
        rd_io(SCRATCH_REG_0, 8'h69);
        core.access(2, 8'h22, 8'h00, rd, vl);
        `CHK("mirror read", 8'h5A, rd)
        core.access(2, 8'h1E, 8'h00, rd, vl);
        `CHK("below mirror", 1'b0, vl)
    endtask : t_mirror

    // Extended region goes out on the forward strobes only
    task automatic t_ext();
        core.access(2, 8'h60, 8'h00, rd, vl);
        `CHK("ext load", 2'b10, {core.ext_seen, vl})
        core.access(3, 8'hFF, 8'h11, rd, vl);
        `CHK("ext store", 1'b1, core.ext_seen)
        core.access(2, 8'h5F, 8'h00, rd, vl);
        `CHK("last local", 2'b01, {core.ext_seen, vl})
    endtask : t_ext

    // Bit set and clear walk every bit, then the top bit-addressable location
    task automatic t_bitops();
        ex = 8'h00;
        wr_io(OUTPUT_LATCH_A, ex);
        for (int b = 0; b < 16; b++) begin
            ex[b % 8] = (b < 8);
            core.bit_op(b < 8 ? 0 : 1, 5'h02, 3'(b), res, vl);
            `CHK("bit op latch", ex, port_output[7:0])
        end
        core.bit_op(0, 5'h1F, 3'h0, res, vl);
        rd_io(EEPROM_CONTROL, 8'h01);
        core.bit_op(1, 5'h1F, 3'h0, res, vl);
        rd_io(EEPROM_CONTROL, 8'h00);
    endtask : t_bitops

    // Skip tests look at one selected bit
    task automatic t_skip();
        wr_io(DIRECTION_A, 8'h08);
        for (int b = 0; b < 8; b++) begin
            core.bit_op(2, 5'h01, 3'(b), res, vl);
            `CHK("skip if set", {1'b1, b == 3}, {vl, res})
            core.bit_op(3, 5'h01, 3'(b), res, vl);
            `CHK("skip if clear", {1'b1, b != 3}, {vl, res})
        end
    endtask : t_skip

    // Flags: set by hardware, kept by zero, cleared by one, cleared by a bit rewrite
    task automatic t_flags();
        logic [5:0] fa [5];
        logic [7:0] fm [5];
        fa = '{TIMER0_FLAGS, TIMER1_FLAGS, TIMER2_FLAGS, PIN_CHG_FLAGS, EXT_IRQ_FLAGS};
        fm = '{FLAGS_TIMER0, FLAGS_TIMER1, FLAGS_TIMER2, FLAGS_PIN_CHG, FLAGS_EXT_IRQ};
        @(negedge clock);
        {t0_set, t1_set, t2_set, pc_set, ei_set, cmp_set, cmp_level} = {40'hFF_FFFF_FFFF, 2'b11};
        @(negedge clock);
        {t0_set, t1_set, t2_set, pc_set, ei_set, cmp_set} = '0;
        for (int i = 0; i < 5; i++) begin
            rd_io(fa[i], fm[i]);
            wr_io(fa[i], 8'h00);
            rd_io(fa[i], fm[i]);
            wr_io(fa[i], 8'h01);
            rd_io(fa[i], fm[i] & 8'hFE);
            core.bit_op(0, fa[i][4:0], 3'h7, res, vl);
            rd_io(fa[i], 8'h00);
        end
        rd_io(COMPARATOR_CS, 8'h30);
        wr_io(COMPARATOR_CS, 8'h10);
        rd_io(COMPARATOR_CS, 8'h20);
        cmp_level = 1'b0;
    endtask : t_flags

    // Reserved bits read back as zero
    task automatic t_reserved_bits();
        wr_io(EXT_IRQ_MASK, 8'hFF);
        rd_io(EXT_IRQ_MASK, MASK_EXT_IRQ);
        wr_io(EEPROM_ADDR_HI, 8'hFF);
        rd_io(EEPROM_ADDR_HI, MASK_EE_ADR_HI);
    endtask : t_reserved_bits

    // Main sequence: two cycles of reset, then every scenario
    initial begin
        reset = 1'b1;
        pin_level = 32'h0000_0000;
        {t0_set, t1_set, t2_set, pc_set, ei_set, cmp_set, cmp_level} = '0;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        t_reset_map();
        t_ports();
        t_mirror();
        t_ext();
        t_bitops();
        t_skip();
        t_flags();
        t_reserved_bits();
        test_done();
    end

    // Watchdog: the scenarios need well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        test_done();
    end
endmodule : io_register_space_decoder_tb_top
